// >>> common/ccg_cmd_if.sv
// interface: checked command passed from the gate to its validity table
`timescale 1ns/1ns
interface ccg_cmd_if;
  import ccg_pkg::*;
  ccg_mode_t  mode;
  ccg_cmd_t   cmd;
  logic       refuse;
  logic [7:0] err_num;
  modport gate  (output mode, output cmd, input refuse, input err_num);
  modport table_side (input mode, input cmd, output refuse, output err_num);
endinterface

// >>> common/ccg_pkg.sv
// package: modes, command codes, error numbers for the calibration command gate
package ccg_pkg;

  // ********************************************************************
  // operating modes
  // ********************************************************************
  typedef enum logic [2:0] {
    CCG_MODE_NORMAL   = 3'h0,
    CCG_MODE_SELFTEST = 3'h1,
    CCG_MODE_CAL_AD   = 3'h3,
    CCG_MODE_CAL_OG   = 3'h2,
    CCG_MODE_CAL_HF   = 3'h6,
    CCG_MODE_CAL_VER  = 3'h7
  } ccg_mode_t;

  localparam ccg_mode_t CCG_MODE_RST = CCG_MODE_NORMAL;

  // ********************************************************************
  // command classes, one code per command family
  // ********************************************************************
  typedef enum logic [4:0] {
    CCG_CMD_OFFSET      = 5'h00,
    CCG_CMD_STORE       = 5'h01,
    CCG_CMD_SEL_ADC     = 5'h02,
    CCG_CMD_SEL_HF      = 5'h03,
    CCG_CMD_ERASE       = 5'h04,
    CCG_CMD_DIGITS      = 5'h05,
    CCG_CMD_FUNC        = 5'h06,
    CCG_CMD_GET_OUT     = 5'h07,
    CCG_CMD_GET_CFG     = 5'h08,
    CCG_CMD_FETCH_PRMT  = 5'h09,
    CCG_CMD_GET_STR     = 5'h0a,
    CCG_CMD_GET_OTHER   = 5'h0b,
    CCG_CMD_NUMBER      = 5'h0c,
    CCG_CMD_PUT_CFG     = 5'h0d,
    CCG_CMD_PUT_MASK    = 5'h0e,
    CCG_CMD_PUT_VAR     = 5'h0f,
    CCG_CMD_PUT_STR     = 5'h10,
    CCG_CMD_AUTORANGE   = 5'h11,
    CCG_CMD_RANGE       = 5'h12,
    CCG_CMD_RANGE7      = 5'h13,
    CCG_CMD_RANGE8      = 5'h14,
    CCG_CMD_RATE        = 5'h15,
    CCG_CMD_TRIG        = 5'h16,
    CCG_CMD_TERM        = 5'h17,
    CCG_CMD_CLR_ERR     = 5'h18,
    CCG_CMD_OTHER       = 5'h19,
    CCG_CMD_RESET       = 5'h1a,
    CCG_CMD_TRIG_NOW    = 5'h1b,
    CCG_CMD_QUERY       = 5'h1c
  } ccg_cmd_t;

  // ********************************************************************
  // error numbers reported on refusal
  // ********************************************************************
  localparam logic [7:0] CCG_ERR_NONE     = 8'h00;
  localparam logic [7:0] CCG_ERR_NORMAL   = 8'h33;
  localparam logic [7:0] CCG_ERR_CAL      = 8'h34;
  localparam logic [7:0] CCG_ERR_VERIFY   = 8'h36;
  localparam logic [7:0] CCG_ERR_ADC_VAR  = 8'h38;
  localparam logic [7:0] CCG_ERR_SELFTEST = 8'h3c;

  // serial poll status bits: step complete and service request
  localparam int         CCG_SPOLL_STEP_BIT = 3;
  localparam int         CCG_SPOLL_SRQ_BIT  = 6;
  localparam logic [7:0] CCG_SPOLL_RST      = 8'h08;
  localparam logic [7:0] CCG_MASK_RST       = 8'h00;

endpackage

// >>> dv/ccg_exec_model.sv
// model: execution side answering each forwarded command
`timescale 1ns/1ns
module ccg_exec_model (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       exec_valid_i,
  input  wire logic [7:0] lat_i,
  output logic            exec_done_o
);
  // ******************************************************************
  // latency counter
  // ******************************************************************
  // seconds-long store and erase shrink to lat_i + 1 cycles from exec_valid_i to exec_done_o
  logic [7:0] cnt;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 8'h00;
      exec_done_o <= 1'b0;
    end else begin
      exec_done_o <= (cnt == 8'h01);
      if (exec_valid_i) cnt <= lat_i;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
  end
endmodule

// >>> dv/ccg_gate_properties.sv
// checker: port relations of the command gate
`timescale 1ns/1ns
module ccg_gate_properties
  import ccg_pkg::*;
(
  input wire logic               REF_CLK_I,
  input wire logic               ARST_N_I,
  input wire logic               CMD_VALID_I,
  input wire ccg_pkg::ccg_cmd_t  CMD_I,
  input wire logic               MODE_LOAD_I,
  input wire ccg_pkg::ccg_mode_t MODE_I,
  input wire logic               EXEC_DONE_I,
  input wire logic               CMD_READY_O,
  input wire logic               EXEC_VALID_O,
  input wire ccg_pkg::ccg_cmd_t  EXEC_CMD_O,
  input wire logic               ERASE_ALL_O,
  input wire logic               REFUSE_O,
  input wire logic [7:0]         ERR_NUM_O,
  input wire logic               ERASE_PEND_O,
  input wire logic               STEP_DONE_O,
  input wire logic [7:0]         SPOLL_O,
  input wire logic               SRQ_O,
  input wire ccg_pkg::ccg_mode_t MODE_O,
  input wire logic               SAMPLE_DONE_O
);
  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  wire take = CMD_VALID_I && CMD_READY_O;
  sequence s_pair;
    ERASE_PEND_O && take && CMD_I == CCG_CMD_STORE &&
    MODE_O inside {CCG_MODE_CAL_AD, CCG_MODE_CAL_OG, CCG_MODE_CAL_HF};
  endsequence
  sequence s_fwd_store;
    EXEC_VALID_O && EXEC_CMD_O == CCG_CMD_STORE;
  endsequence
  normal_err_a: assert property (
    take && MODE_O == CCG_MODE_NORMAL && CMD_I == CCG_CMD_STORE
    |=> REFUSE_O && ERR_NUM_O == CCG_ERR_NORMAL) else $error("normal err");
  selftest_err_a: assert property (
    take && MODE_O == CCG_MODE_SELFTEST && CMD_I == CCG_CMD_STORE
    |=> REFUSE_O && ERR_NUM_O == CCG_ERR_SELFTEST) else $error("test err");
  verify_err_a: assert property (
    take && MODE_O == CCG_MODE_CAL_VER && CMD_I == CCG_CMD_FETCH_PRMT
    |=> REFUSE_O && ERR_NUM_O == CCG_ERR_VERIFY) else $error("verify err");
  adc_var_a: assert property (
    take && MODE_O == CCG_MODE_CAL_AD && CMD_I == CCG_CMD_PUT_VAR
    |=> REFUSE_O && ERR_NUM_O == CCG_ERR_ADC_VAR) else $error("adc var");
  step_clear_a: assert property (
    EXEC_VALID_O |-> !STEP_DONE_O) else $error("step not cleared");
  step_set_a: assert property (
    EXEC_DONE_I && !CMD_READY_O |=> STEP_DONE_O && CMD_READY_O)
    else $error("step not set");
  srq_step_a: assert property (
    $rose(SRQ_O) |-> STEP_DONE_O && SPOLL_O[CCG_SPOLL_SRQ_BIT] &&
    SPOLL_O[CCG_SPOLL_STEP_BIT])
    else $error("srq without step");
  erase_pair_a: assert property (
    s_pair |=> s_fwd_store ##0 ERASE_ALL_O) else $error("no erase");
  erase_drop_a: assert property (
    ERASE_PEND_O && take && CMD_I != CCG_CMD_STORE && CMD_I != CCG_CMD_ERASE
    |=> !ERASE_PEND_O && !ERASE_ALL_O) else $error("erase kept");
  erase_only_a: assert property (
    take && CMD_I == CCG_CMD_ERASE |=> !EXEC_VALID_O)
    else $error("erase forwarded");
  erase_hold_a: assert property (
    ERASE_PEND_O && !take |=> ERASE_PEND_O) else $error("erase expired");
  cal_quiet_a: assert property (
    $past(MODE_O) != CCG_MODE_NORMAL && $past(MODE_O) != CCG_MODE_CAL_VER
    |-> !SAMPLE_DONE_O) else $error("sample in cal");
  mode_load_a: assert property (
    MODE_LOAD_I |=> MODE_O == $past(MODE_I)) else $error("mode load");
endmodule

// >>> dv/ccg_gate_tb.sv
// bench: command gate against the execution model
`timescale 1ns/1ns
module ccg_gate_tb;
  import ccg_pkg::*;
  typedef struct packed {
    ccg_mode_t  mode;
    ccg_cmd_t   cmd;
    logic [7:0] err;
  } ccg_row_t;
  // ******************************************************************
  // rows: err 00 means forwarded
  // ******************************************************************
  localparam ccg_row_t ROWS [15] = '{
    '{CCG_MODE_NORMAL, CCG_CMD_STORE, CCG_ERR_NORMAL},
    '{CCG_MODE_NORMAL, CCG_CMD_ERASE, CCG_ERR_NORMAL},
    '{CCG_MODE_NORMAL, CCG_CMD_OFFSET, CCG_ERR_NONE},
    '{CCG_MODE_SELFTEST, CCG_CMD_STORE, CCG_ERR_SELFTEST},
    '{CCG_MODE_SELFTEST, CCG_CMD_QUERY, CCG_ERR_SELFTEST},
    '{CCG_MODE_CAL_AD, CCG_CMD_OFFSET, CCG_ERR_CAL},
    '{CCG_MODE_CAL_AD, CCG_CMD_PUT_VAR, CCG_ERR_ADC_VAR},
    '{CCG_MODE_CAL_OG, CCG_CMD_RANGE8, CCG_ERR_NONE},
    '{CCG_MODE_CAL_OG, CCG_CMD_RATE, CCG_ERR_CAL},
    '{CCG_MODE_CAL_HF, CCG_CMD_RANGE8, CCG_ERR_CAL},
    '{CCG_MODE_CAL_HF, CCG_CMD_FETCH_PRMT, CCG_ERR_NONE},
    '{CCG_MODE_CAL_VER, CCG_CMD_STORE, CCG_ERR_VERIFY},
    '{CCG_MODE_CAL_VER, CCG_CMD_FETCH_PRMT, CCG_ERR_VERIFY},
    '{CCG_MODE_CAL_VER, CCG_CMD_PUT_VAR, CCG_ERR_VERIFY},
    '{CCG_MODE_CAL_VER, CCG_CMD_RATE, CCG_ERR_NONE}};
  logic clk = 1'b0, arst_n, cmd_valid, mode_load, exec_done, samp_in;
  logic spoll_ack, ready, exec_valid, erase_all, refuse, erase_pend;
  logic step_done, srq, samp_out;
  logic [7:0] arg, exec_arg, err_num, spoll, lat;
  ccg_cmd_t cmd, exec_cmd;
  ccg_mode_t mode_in, mode_out;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  ccg_gate ccg_gate_inst (.REF_CLK_I(clk), .ARST_N_I(arst_n),
    .CMD_VALID_I(cmd_valid), .CMD_I(cmd), .CMD_ARG_I(arg),
    .MODE_LOAD_I(mode_load), .MODE_I(mode_in), .EXEC_DONE_I(exec_done),
    .SAMPLE_DONE_I(samp_in), .SPOLL_ACK_I(spoll_ack), .CMD_READY_O(ready),
    .EXEC_VALID_O(exec_valid), .EXEC_CMD_O(exec_cmd), .EXEC_ARG_O(exec_arg),
    .ERASE_ALL_O(erase_all), .REFUSE_O(refuse), .ERR_NUM_O(err_num),
    .ERASE_PEND_O(erase_pend), .STEP_DONE_O(step_done), .SPOLL_O(spoll),
    .SRQ_O(srq), .MODE_O(mode_out), .SAMPLE_DONE_O(samp_out));
  ccg_exec_model ccg_exec_model_inst (.clk_i(clk), .arst_n_i(arst_n),
    .exec_valid_i(exec_valid), .lat_i(lat), .exec_done_o(exec_done));
  always #20 clk = ~clk;
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic go(input ccg_cmd_t c, input logic [7:0] a);
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd = c;
    arg = a;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
  endtask
  task automatic pulse_ack();
    @(posedge clk);
    #1 spoll_ack = 1'b1;
    @(posedge clk);
    #1 spoll_ack = 1'b0;
  endtask
  // completion found by polling, never by a fixed delay
  task automatic idle();
    for (int i = 0; i < 60 && ready !== 1'b1; i++) @(posedge clk) #1;
    chk("ready", 8'h01, 8'(ready));
  endtask
  task automatic set_mode(input ccg_mode_t m);
    @(posedge clk);
    #1 mode_load = 1'b1;
    mode_in = m;
    @(posedge clk);
    #1 mode_load = 1'b0;
    chk("mode", 8'(m), 8'(mode_out));
  endtask
  initial begin
    {cmd_valid, mode_load, samp_in, spoll_ack, arst_n} = 5'h00;
    cmd = CCG_CMD_OFFSET;
    arg = 8'h00;
    mode_in = CCG_MODE_NORMAL;
    lat = 8'h02;
    repeat (20) @(posedge clk);
    chk("spoll", CCG_SPOLL_RST, spoll);
    #1 arst_n = 1'b1;
    foreach (ROWS[r]) begin
      set_mode(ROWS[r].mode);
      go(ROWS[r].cmd, 8'h00);
      chk("refuse", 8'(ROWS[r].err != 8'h00), 8'(refuse));
      if (ROWS[r].err != 8'h00) chk("err", ROWS[r].err, err_num);
      else chk("fwd", 8'h01, 8'(exec_valid));
      idle();
    end
    $display("table rows done");
    lat = 8'h14;
    set_mode(CCG_MODE_CAL_AD);
    go(CCG_CMD_CLR_ERR, 8'h00);
    chk("err", CCG_ERR_NONE, err_num);
    idle();
    go(CCG_CMD_PUT_MASK, 8'h08);
    chk("arg", 8'h08, exec_arg);
    chk("cmd", 8'(CCG_CMD_PUT_MASK), 8'(exec_cmd));
    idle();
    pulse_ack();
    go(CCG_CMD_STORE, 8'h00);
    chk("step", 8'h00, 8'(step_done));
    chk("srq", 8'h00, 8'(srq));
    idle();
    chk("spoll", 8'h48, spoll);
    pulse_ack();
    chk("srq", 8'h00, 8'(srq));
    $display("step complete test done");
    go(CCG_CMD_ERASE, 8'h00);
    chk("pend", 8'h01, 8'(erase_pend));
    chk("fwd", 8'h00, 8'(exec_valid));
    repeat (40) @(posedge clk);
    chk("pend", 8'h01, 8'(erase_pend));
    go(CCG_CMD_STORE, 8'h00);
    chk("erase", 8'h01, 8'(erase_all));
    idle();
    go(CCG_CMD_ERASE, 8'h00);
    go(CCG_CMD_FETCH_PRMT, 8'h00);
    chk("pend", 8'h00, 8'(erase_pend));
    chk("erase", 8'h00, 8'(erase_all));
    idle();
    go(CCG_CMD_STORE, 8'h00);
    chk("erase", 8'h00, 8'(erase_all));
    idle();
    $display("erase test done");
    set_mode(CCG_MODE_CAL_OG);
    go(CCG_CMD_SEL_HF, 8'h00);
    chk("mode", 8'(CCG_MODE_CAL_HF), 8'(mode_out));
    idle();
    go(CCG_CMD_SEL_ADC, 8'h00);
    chk("mode", 8'(CCG_MODE_CAL_AD), 8'(mode_out));
    idle();
    $display("mode select test done");
    samp_in = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("sample", 8'h00, 8'(samp_out));
    set_mode(CCG_MODE_CAL_VER);
    @(posedge clk);
    #1 chk("sample", 8'h01, 8'(samp_out));
    $display("sample test done");
    arst_n = 1'b0;
    #1 chk("mode", 8'(CCG_MODE_RST), 8'(mode_out));
    chk("err", CCG_ERR_NONE, err_num);
    chk("spoll", CCG_SPOLL_RST, spoll);
    chk("ready", 8'h01, 8'(ready));
    $display("reset test done");
    finish_test();
  end
endmodule
bind ccg_gate ccg_gate_properties ccg_gate_properties_inst (.*);

// >>> src/ccg_gate.sv
// top: command gate, step-complete tracking and remote erase pairing
`timescale 1ns/1ns
// What this block does, and what its controller does
// (R01) refuse mode-invalid commands with mode error number
// (R02) verification and converter cal use distinct numbers
// (R03) clear step complete on each hand-off
// (R04) set step complete when command finishes
// (R05) masked service request on step completion
// (R06) controller waits up to 22 s after store
// (R07) full erase only on erase then store
// (R08) other command after erase abandons erasure
// (R09) pending erase never times out
// (R10) no partial erasure over the bus
// (R11) controller waits up to 3 s for erase
// (R12) controller sends erase and store together
// (R13) controller polls, waits for request, or delays
// (R14) sample complete quiet in cal except verification
// (R15) mode register selects validity and error number
module ccg_gate (
  input  wire logic                REF_CLK_I,
  input  wire logic                ARST_N_I,
  input  wire logic                CMD_VALID_I,
  input  wire ccg_pkg::ccg_cmd_t   CMD_I,
  input  wire logic [7:0]          CMD_ARG_I,
  input  wire logic                MODE_LOAD_I,
  input  wire ccg_pkg::ccg_mode_t  MODE_I,
  input  wire logic                EXEC_DONE_I,
  input  wire logic                SAMPLE_DONE_I,
  input  wire logic                SPOLL_ACK_I,
  output logic                     CMD_READY_O,
  output logic                     EXEC_VALID_O,
  output ccg_pkg::ccg_cmd_t        EXEC_CMD_O,
  output logic [7:0]               EXEC_ARG_O,
  output logic                     ERASE_ALL_O,
  output logic                     REFUSE_O,
  output logic [7:0]               ERR_NUM_O,
  output logic                     ERASE_PEND_O,
  output logic                     STEP_DONE_O,
  output logic [7:0]               SPOLL_O,
  output logic                     SRQ_O,
  output ccg_pkg::ccg_mode_t       MODE_O,
  output logic                     SAMPLE_DONE_O
);
  import ccg_pkg::*;

  // ********************************************************************
  // state
  // ********************************************************************
  typedef enum logic [1:0] {
    CCG_ST_IDLE  = 2'h0,
    CCG_ST_BUSY  = 2'h1
  } ccg_state_t;

  ccg_cmd_if  chk ();
  ccg_state_t state;
  ccg_mode_t  mode;
  logic       erase_pend;
  logic       step_done;
  logic       srq_mask;
  logic       srq;
  logic       take;
  logic       pass;

  ccg_valid_table u_table (
    .chk (chk)
  );

  assign chk.mode = mode;
  assign chk.cmd  = CMD_I;

  // one command in flight; the input buffer stalls behind a slow store
  assign CMD_READY_O = (state == CCG_ST_IDLE);
  assign take        = CMD_VALID_I && CMD_READY_O;
  assign pass        = take && !chk.refuse;

  // ********************************************************************
  // mode register
  // ********************************************************************
  // a mode load overrides a sub-mode select in the same cycle
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mode <= CCG_MODE_RST;
    end else if (MODE_LOAD_I) begin
      mode <= MODE_I; // (R15)
    end else if (pass && mode != CCG_MODE_NORMAL &&
                 mode != CCG_MODE_SELFTEST) begin
      if (CMD_I == CCG_CMD_SEL_ADC) begin
        mode <= CCG_MODE_CAL_AD;
      end else if (CMD_I == CCG_CMD_SEL_HF) begin
        mode <= CCG_MODE_CAL_HF;
      end
    end
  end

  // ********************************************************************
  // hand-off to execution side
  // ********************************************************************
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= CCG_ST_IDLE;
    end else begin
      case (state)
        CCG_ST_IDLE: begin
          if (pass && !(CMD_I == CCG_CMD_ERASE)) begin
            state <= CCG_ST_BUSY;
          end
        end
        CCG_ST_BUSY: begin
          if (EXEC_DONE_I) begin
            state <= CCG_ST_IDLE;
          end
        end
        default: state <= CCG_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      EXEC_VALID_O <= 1'b0;
      EXEC_CMD_O   <= CCG_CMD_OFFSET;
      EXEC_ARG_O   <= 8'h00;
      ERASE_ALL_O  <= 1'b0;
    end else begin
      // erase alone is held here, not forwarded: no partial erase path
      EXEC_VALID_O <= pass && CMD_I != CCG_CMD_ERASE; // (R10)
      ERASE_ALL_O  <= pass && erase_pend && CMD_I == CCG_CMD_STORE; // (R07)
      if (pass) begin
        EXEC_CMD_O <= CMD_I;
        EXEC_ARG_O <= CMD_ARG_I;
      end
    end
  end

  // ********************************************************************
  // erase pairing
  // ********************************************************************
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      erase_pend <= 1'b0;
    end else if (take) begin
      // no timer: only the next command ends the pending erase
      erase_pend <= pass && CMD_I == CCG_CMD_ERASE; // (R08) (R09)
    end
  end

  // ********************************************************************
  // refusal report
  // ********************************************************************
  // a refused command still ends a pending erase through take
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REFUSE_O  <= 1'b0;
      ERR_NUM_O <= CCG_ERR_NONE;
    end else begin
      REFUSE_O <= take && chk.refuse; // (R01)
      if (take && chk.refuse) begin
        ERR_NUM_O <= chk.err_num; // (R02)
      end else if (take && CMD_I == CCG_CMD_CLR_ERR) begin
        ERR_NUM_O <= CCG_ERR_NONE;
      end
    end
  end

  // ********************************************************************
  // step complete, mask, service request
  // ********************************************************************
  // set beats clear; they cannot meet with one command in flight
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      step_done <= 1'b1;
    end else if (EXEC_DONE_I && state == CCG_ST_BUSY) begin
      step_done <= 1'b1; // (R04)
    end else if (pass && CMD_I != CCG_CMD_ERASE) begin
      step_done <= 1'b0; // (R03)
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      srq_mask <= 1'b0;
    end else if (pass && CMD_I == CCG_CMD_PUT_MASK) begin
      srq_mask <= CMD_ARG_I[CCG_SPOLL_STEP_BIT];
    end
  end

  // request set on completion wins over the poll acknowledge
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      srq <= 1'b0;
    end else if (EXEC_DONE_I && state == CCG_ST_BUSY && srq_mask) begin
      srq <= 1'b1; // (R05)
    end else if (SPOLL_ACK_I) begin
      srq <= 1'b0;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  // selftest readings are not real, so the pulse is blocked there too
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SAMPLE_DONE_O <= 1'b0;
    end else begin
      SAMPLE_DONE_O <= SAMPLE_DONE_I && (mode == CCG_MODE_NORMAL ||
                       mode == CCG_MODE_CAL_VER); // (R14)
    end
  end

  always_comb begin
    SPOLL_O                     = 8'h00;
    SPOLL_O[CCG_SPOLL_STEP_BIT] = step_done; // (R05)
    SPOLL_O[CCG_SPOLL_SRQ_BIT]  = srq;
  end

  assign SRQ_O        = srq;
  assign STEP_DONE_O  = step_done;
  assign ERASE_PEND_O = erase_pend;
  assign MODE_O       = mode;

endmodule

// >>> src/ccg_valid_table.sv
// validity table: per mode and command, refusal and error number
`timescale 1ns/1ns
module ccg_valid_table (
  ccg_cmd_if.table_side  chk
);
  import ccg_pkg::*;

  // ********************************************************************
  // lookup
  // ********************************************************************
  logic       cal_bad;
  logic       all_but_ver;
  logic       st_bad;
  logic       nm_bad;

  always_comb begin
    // commands refused in every cal sub-mode (and self-test)
    all_but_ver = 1'b0;
    cal_bad     = 1'b0;
    case (chk.cmd)
      CCG_CMD_OFFSET, CCG_CMD_DIGITS, CCG_CMD_PUT_CFG, CCG_CMD_AUTORANGE,
      CCG_CMD_RANGE, CCG_CMD_RANGE7, CCG_CMD_TRIG, CCG_CMD_RESET,
      CCG_CMD_TRIG_NOW: cal_bad = 1'b1;
      CCG_CMD_RANGE8, CCG_CMD_RATE: all_but_ver = 1'b1;
      default: cal_bad = 1'b0;
    endcase
    case (chk.cmd)
      CCG_CMD_GET_OUT, CCG_CMD_GET_CFG, CCG_CMD_GET_OTHER, CCG_CMD_NUMBER,
      CCG_CMD_PUT_MASK, CCG_CMD_TERM, CCG_CMD_CLR_ERR,
      CCG_CMD_OTHER: st_bad = 1'b0;
      default: st_bad = 1'b1;
    endcase
    case (chk.cmd)
      CCG_CMD_STORE, CCG_CMD_SEL_ADC, CCG_CMD_SEL_HF, CCG_CMD_ERASE,
      CCG_CMD_FETCH_PRMT, CCG_CMD_PUT_VAR, CCG_CMD_PUT_STR: nm_bad = 1'b1;
      default: nm_bad = 1'b0;
    endcase
  end

  always_comb begin
    chk.refuse  = 1'b0;
    chk.err_num = CCG_ERR_NONE;
    case (chk.mode) // (R01) (R15)
      CCG_MODE_NORMAL: begin
        chk.refuse  = nm_bad;
        chk.err_num = nm_bad ? CCG_ERR_NORMAL : CCG_ERR_NONE;
      end
      CCG_MODE_SELFTEST: begin
        chk.refuse  = st_bad;
        chk.err_num = st_bad ? CCG_ERR_SELFTEST : CCG_ERR_NONE;
      end
      CCG_MODE_CAL_VER: begin
        if (chk.cmd == CCG_CMD_STORE || chk.cmd == CCG_CMD_FETCH_PRMT ||
            chk.cmd == CCG_CMD_PUT_VAR) begin
          chk.refuse  = 1'b1; // (R02)
          chk.err_num = CCG_ERR_VERIFY;
        end else if (cal_bad) begin
          chk.refuse  = 1'b1;
          chk.err_num = CCG_ERR_CAL;
        end
      end
      CCG_MODE_CAL_AD, CCG_MODE_CAL_OG, CCG_MODE_CAL_HF: begin
        if (chk.mode == CCG_MODE_CAL_AD && chk.cmd == CCG_CMD_PUT_VAR) begin
          chk.refuse  = 1'b1; // (R02)
          chk.err_num = CCG_ERR_ADC_VAR;
        end else if (cal_bad || (all_but_ver &&
                     !(chk.mode == CCG_MODE_CAL_OG &&
                       chk.cmd == CCG_CMD_RANGE8))) begin
          chk.refuse  = 1'b1;
          chk.err_num = CCG_ERR_CAL;
        end
      end
      default: begin
        chk.refuse  = 1'b0;
        chk.err_num = CCG_ERR_NONE;
      end
    endcase
  end

endmodule
